// *** pkg/rfs_pkg.sv ***
// Package for the receive frame status word block
package rfs_pkg;
   // Status word bit positions, and the global status watchdog bit
   localparam int BIT_OVF    = 0;
   localparam int BIT_CRC    = 1;
   localparam int BIT_DRIB   = 2;
   localparam int BIT_ONE    = 3;
   localparam int BIT_WDOG   = 4;
   localparam int BIT_FTYPE  = 5;
   localparam int BIT_LATE   = 6;
   localparam int BIT_LONG   = 7;
   localparam int BIT_LAST   = 8;
   localparam int BIT_RUNT   = 11;
   localparam int BIT_DERR   = 14;
   localparam int BIT_ESUM   = 15;
   localparam int FL_LSB     = 16;
   localparam int FL_MSB     = 30;
   localparam int GSR_WDOG   = 9;
   // Frame limits in bytes
   localparam logic [14:0] MAX_FRAME    = 15'h05ee;
   localparam logic [15:0] MAX_LEN_FLD  = 16'h05dc;
   localparam logic [14:0] LATE_BYTES   = 15'h0040;
   localparam logic [14:0] WDOG_BYTES   = 15'h0800;
   localparam logic [14:0] TYPE_MIN_LEN = 15'h000e;
   // Dribble bit values and status word reset value
   localparam logic [2:0]  DRIB_MII     = 3'h4;
   localparam logic [2:0]  DRIB_SER     = 3'h3;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0008;

   // Per-frame end information from the receive path
   typedef struct packed {
      logic        last_desc;
      logic        runt;
      logic        desc_err;
      logic        crc_bad;
      logic        fifo_ovf;
      logic [2:0]  drib_bits;
      logic [14:0] length;
      logic [15:0] len_type;
   } rfs_end_t;
endpackage

// *** design/rfs_status.sv ***
// Builds the status bits and frame length field of the receive status word
`timescale 1ns/1ps
module rfs_status
   import rfs_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Receive path events
   input  wire logic        rx_start,
   input  wire logic        rx_byte,
   input  wire logic        rx_collision,
   input  wire logic        rx_phy_err,
   input  wire logic        symbol_mode,
   input  wire logic        rx_end,
   input  wire rfs_end_t    rx_info,
   // Status word and global status
   output logic      [31:0] rx_status_word,
   output logic             rx_status_valid,
   output logic             gsr_wdog_set
);
   typedef enum logic [1:0] {
      RFS_IDLE = 2'b01,
      RFS_RECV = 2'b10
   } rfs_state_t;

   rfs_state_t  state;
   rfs_state_t  next_state;
   logic [14:0] count;
   logic [14:0] next_count;
   logic        late;
   logic        next_late;
   logic        wdog;
   logic        next_wdog;
   logic        phy_err;
   logic        next_phy_err;
   logic [31:0] next_word;
   logic        next_valid;
   logic        next_gsr;
   logic        ovf_n;
   logic        crc_n;
   logic        drib_n;
   logic        long_n;
   logic        late_n;
   logic        wdog_n;
   logic        ftype_n;

   always_comb begin
      next_state   = state;
      next_count   = count;
      next_late    = late;
      next_wdog    = wdog;
      next_phy_err = phy_err;
      unique case (state)
         RFS_IDLE: begin
            if (rx_start) begin
               next_state   = RFS_RECV;
               next_count   = '0;
               next_late    = 1'b0;
               next_wdog    = 1'b0;
               next_phy_err = rx_phy_err;
            end
         end
         RFS_RECV: begin
            // Bytes counted until count reaches all ones, then held; never cut short
            if (rx_byte && count != '1) begin
               next_count = count + 15'h0001;
            end
            if (rx_collision && count >= LATE_BYTES) begin
               next_late = 1'b1;
            end
            if (count >= WDOG_BYTES) begin
               next_wdog = 1'b1;
            end
            if (rx_phy_err) begin
               next_phy_err = 1'b1;
            end
            if (rx_end) begin
               next_state = RFS_IDLE;
            end
         end
         default: next_state = RFS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state   <= RFS_IDLE;
         count   <= '0;
         late    <= 1'b0;
         wdog    <= 1'b0;
         phy_err <= 1'b0;
      end else begin
         state   <= next_state;
         count   <= next_count;
         late    <= next_late;
         wdog    <= next_wdog;
         phy_err <= next_phy_err;
      end
   end

   // Flag values at frame end
   always_comb begin
      long_n  = rx_info.length > MAX_FRAME;
      late_n  = late | (rx_collision && count >= LATE_BYTES);
      wdog_n  = wdog | (count >= WDOG_BYTES);
      ftype_n = rx_info.len_type > MAX_LEN_FLD;
      crc_n   = rx_info.crc_bad | phy_err | rx_phy_err;
      ovf_n   = rx_info.fifo_ovf;
      drib_n  = symbol_mode ? (rx_info.drib_bits == DRIB_MII)
                            : (rx_info.drib_bits >= DRIB_SER);
   end

   always_comb begin
      next_word  = rx_status_word;
      next_valid = 1'b0;
      next_gsr   = 1'b0;
      if (state == RFS_RECV && rx_end) begin
         next_word              = WORD_RESET;
         next_word[BIT_OVF]     = ovf_n;
         next_word[BIT_CRC]     = crc_n;
         next_word[BIT_DRIB]    = drib_n;
         next_word[BIT_ONE]     = 1'b1;
         next_word[BIT_WDOG]    = wdog_n;
         next_word[BIT_FTYPE]   = ftype_n;
         next_word[BIT_LATE]    = late_n;
         next_word[BIT_LONG]    = long_n;
         next_word[BIT_LAST]    = rx_info.last_desc;
         next_word[BIT_RUNT]    = rx_info.runt;
         next_word[BIT_DERR]    = rx_info.desc_err;
         next_word[BIT_ESUM]    = ovf_n | crc_n | late_n | long_n
                                  | rx_info.runt | rx_info.desc_err;
         next_word[FL_MSB:FL_LSB] = rx_info.length;
         next_valid             = 1'b1;
         next_gsr               = wdog_n;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rx_status_word  <= WORD_RESET;
         rx_status_valid <= 1'b0;
         gsr_wdog_set    <= 1'b0;
      end else begin
         rx_status_word  <= next_word;
         rx_status_valid <= next_valid;
         gsr_wdog_set    <= next_gsr;
      end
   end

   a_fixed_one: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rx_status_word[BIT_ONE])
      else $error("fixed bit low");
   a_wdog_gsr: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rx_status_valid |-> gsr_wdog_set == rx_status_word[BIT_WDOG])
      else $error("watchdog global bit mismatch");
   a_esum_or: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rx_status_valid |-> rx_status_word[BIT_ESUM] ==
      (|{rx_status_word[BIT_OVF], rx_status_word[BIT_CRC],
         rx_status_word[BIT_LATE], rx_status_word[BIT_LONG],
         rx_status_word[BIT_RUNT], rx_status_word[BIT_DERR]}))
      else $error("error summary mismatch");
   a_long_len: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      rx_status_valid |-> rx_status_word[BIT_LONG] ==
      (rx_status_word[FL_MSB:FL_LSB] > MAX_FRAME))
      else $error("too-long flag wrong");
   a_ftype_set: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end |=> rx_status_word[BIT_FTYPE] ==
      ($past(rx_info.len_type) > MAX_LEN_FLD))
      else $error("frame type flag wrong");
   a_phy_crc: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && phy_err
      |=> rx_status_word[BIT_CRC])
      else $error("phy error lost");
   a_crc_bad: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && rx_info.crc_bad
      |=> rx_status_word[BIT_CRC])
      else $error("crc flag missing");
   a_ovf_flag: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end |=>
      rx_status_word[BIT_OVF] == $past(rx_info.fifo_ovf))
      else $error("overflow flag wrong");
   a_drib_mii: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && symbol_mode |=>
      rx_status_word[BIT_DRIB] == ($past(rx_info.drib_bits) == DRIB_MII))
      else $error("dribble flag wrong");
   a_drib_ser: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && !symbol_mode |=>
      rx_status_word[BIT_DRIB] == ($past(rx_info.drib_bits) >= DRIB_SER))
      else $error("serial dribble flag wrong");
   a_late_word: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && late |=> rx_status_word[BIT_LATE])
      else $error("late collision lost");
   a_wdog_flag: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_end && count >= WDOG_BYTES
      |=> rx_status_word[BIT_WDOG] && gsr_wdog_set)
      else $error("watchdog flag missing");
   a_no_trunc: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      state == RFS_RECV && rx_byte && !rx_end && count != '1
      |=> state == RFS_RECV && count == $past(count) + 15'h0001)
      else $error("frame reception cut short");
   c_frame_done: cover property (@(posedge ref_clk) rx_status_valid);
   c_drib_seen: cover property (@(posedge ref_clk)
      rx_status_valid && rx_status_word[BIT_DRIB]);
   c_wdog_hit: cover property (@(posedge ref_clk) gsr_wdog_set);
   c_late_col: cover property (@(posedge ref_clk)
      rx_status_valid && rx_status_word[BIT_LATE]);
endmodule

// *** dv/rfs_host.sv ***
// Host-side reader of the receive status word
`timescale 1ns/1ps
module rfs_host
   import rfs_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Status from the block
   input  wire logic [31:0] rx_status_word,
   input  wire logic        rx_status_valid,
   // Host view
   output logic             pkt_good
);
   logic [31:0] w;
   assign w = rx_status_word;
   // Type, length and dribble unused for the verdict
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pkt_good <= 1'b0;
      end else if (rx_status_valid) begin
         pkt_good <= w[BIT_LAST] && !w[BIT_ESUM];
      end
   end
endmodule

// *** dv/rfs_status_test.sv ***
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module rfs_status_test;
   import rfs_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        rx_start = 1'b0;
   logic        rx_byte = 1'b0;
   logic        rx_collision = 1'b0;
   logic        rx_phy_err = 1'b0;
   logic        symbol_mode = 1'b1;
   logic        rx_end = 1'b0;
   rfs_end_t    rx_info = '0;
   logic [31:0] rx_status_word;
   logic        rx_status_valid;
   logic        gsr_wdog_set;
   logic        pkt_good;
   int          n_errors = 0;
   int          checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   rfs_status dut_u (.ref_clk(ref_clk), .rstn(rstn), .rx_start(rx_start),
      .rx_byte(rx_byte), .rx_collision(rx_collision),
      .rx_phy_err(rx_phy_err), .symbol_mode(symbol_mode), .rx_end(rx_end),
      .rx_info(rx_info), .rx_status_word(rx_status_word),
      .rx_status_valid(rx_status_valid), .gsr_wdog_set(gsr_wdog_set));
   rfs_host host_u (.ref_clk(ref_clk), .rstn(rstn),
      .rx_status_word(rx_status_word), .rx_status_valid(rx_status_valid),
      .pkt_good(pkt_good));
   task automatic complete_run;
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic step;
      @(posedge ref_clk);
      #2;
   endtask
   function automatic rfs_end_t mk(input logic [14:0] len,
                                   input logic [15:0] lt, input logic [7:0] f);
      return {f, len, lt};
   endfunction
   // One whole frame, then the word and host verdict are judged
   task automatic frame(input int col, input logic err, input rfs_end_t inf);
      logic [31:0] e;
      e = WORD_RESET;
      e[FL_MSB:FL_LSB] = inf.length;
      e[BIT_LAST] = inf.last_desc;
      e[BIT_RUNT] = inf.runt;
      e[BIT_DERR] = inf.desc_err;
      e[BIT_LONG] = inf.length > MAX_FRAME;
      e[BIT_LATE] = col > int'(LATE_BYTES);
      e[BIT_FTYPE] = inf.len_type > MAX_LEN_FLD;
      e[BIT_WDOG] = inf.length >= WDOG_BYTES;
      e[BIT_DRIB] = symbol_mode ? (inf.drib_bits == DRIB_MII)
                                : (inf.drib_bits >= DRIB_SER);
      e[BIT_CRC] = inf.crc_bad | err;
      e[BIT_OVF] = inf.fifo_ovf;
      e[BIT_ESUM] = |{e[BIT_OVF], e[BIT_CRC], e[BIT_LATE]};
      e[BIT_ESUM] = e[BIT_ESUM] | (|{e[BIT_LONG], e[BIT_RUNT], e[BIT_DERR]});
      rx_start = 1'b1;
      step;
      rx_start = 1'b0;
      rx_phy_err = err;
      for (int i = 1; i <= int'(inf.length); i++) begin
         rx_byte = 1'b1;
         rx_collision = (i == col);
         step;
      end
      rx_byte = 1'b0;
      rx_collision = 1'b0;
      rx_end = 1'b1;
      rx_info = inf;
      step;
      rx_end = 1'b0;
      rx_phy_err = 1'b0;
      cmp_bit(rx_status_valid, 1'b1);
      cmp_word(rx_status_word, e);
      cmp_bit(gsr_wdog_set, e[BIT_WDOG]);
      step;
      cmp_bit(pkt_good, e[BIT_LAST] & ~e[BIT_ESUM]);
   endtask
   task automatic t_type;
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h80));
      frame(0, 1'b0, mk(15'h0040, 16'h05dc, 8'h80));
   endtask
   task automatic t_long;
      frame(0, 1'b0, mk(15'h05ef, 16'h0040, 8'h80));
      frame(0, 1'b0, mk(15'h05ee, 16'h0040, 8'h80));
   endtask
   task automatic t_late;
      frame(100, 1'b0, mk(15'h0080, 16'h0800, 8'h80));
      frame(30, 1'b0, mk(15'h0080, 16'h0800, 8'h80));
      frame(65, 1'b0, mk(15'h0080, 16'h0800, 8'h80));
      frame(64, 1'b0, mk(15'h0080, 16'h0800, 8'h80));
   endtask
   task automatic t_wdog;
      frame(0, 1'b0, mk(15'h0800, 16'h0800, 8'h80));
   endtask
   task automatic t_drib;
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h84));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h83));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h85));
      symbol_mode = 1'b0;
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h83));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h82));
      symbol_mode = 1'b1;
   endtask
   task automatic t_err;
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h90));
      frame(0, 1'b1, mk(15'h0040, 16'h0800, 8'h80));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h88));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'he0));
      frame(0, 1'b0, mk(15'h0040, 16'h0800, 8'h00));
   endtask
   initial begin
      #400us;
      n_errors++;
      complete_run;
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      #2;
      rstn = 1'b1;
      cmp_word(rx_status_word, WORD_RESET);
      rx_end = 1'b1;
      step;
      rx_end = 1'b0;
      cmp_bit(rx_status_valid, 1'b0);
      step;
      cmp_bit(rx_status_valid, 1'b0);
      t_type;
      t_long;
      t_late;
      t_wdog;
      t_drib;
      t_err;
      complete_run;
   end
endmodule
